// >>> common/vrac_pkg.sv
// constants shared by the screen-memory access controller
package vrac_pkg;
    // clock and pixel timing
    localparam int CLK_PERIOD_NS = 50;
    localparam int PIXEL_PERIOD_NS = 200;
    localparam int PIXEL_DIV = (PIXEL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0] PIXEL_DIV_LAST = 2'(PIXEL_DIV - 1);
    localparam int H_TOTAL = 320;
    localparam logic [8:0] H_LAST = 9'(H_TOTAL - 1);
    localparam int RETRACE_NS = 12800;
    localparam int RETRACE_PIXELS = RETRACE_NS / PIXEL_PERIOD_NS;

    // horizontal count bit positions
    localparam int HB0 = 0;
    localparam int HB1 = 1;
    localparam int HB2 = 2;
    localparam int HB3 = 3;
    localparam int HB4 = 4;
    localparam int HB8 = 8;
    localparam logic [2:0] BYTE_LOAD_PIXEL = 3'h7;

    // synchronised input bit positions
    localparam int SY_MEM_REQUEST_N = 0;
    localparam int SY_REFRESH_CYCLE_N = 1;
    localparam int SY_RD = 2;
    localparam int SY_WR = 3;
    localparam int SY_SEL = 4;
    localparam int SY_W = 5;
    localparam logic [4:0] SYNC_RST = 5'h0f;

    // reset values
    localparam logic STROBE_IDLE = 1'b1;
    localparam logic [5:0] ADDR_RST = 6'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [1:0] CS_IDLE = 2'h3;

    // address multiplexer select codes
    typedef enum logic [1:0] {
        VRAC_SEL_VID_ROW = 2'b00,
        VRAC_SEL_VID_COL = 2'b01,
        VRAC_SEL_CPU_ROW = 2'b10,
        VRAC_SEL_CPU_COL = 2'b11
    } vrac_sel_e;

    // logic unit functions
    typedef enum logic [2:0] {
        VRAC_FN_PASS = 3'b000,
        VRAC_FN_XOR = 3'b001,
        VRAC_FN_OR = 3'b010,
        VRAC_FN_NOT_NEW = 3'b011,
        VRAC_FN_NOT_OLD = 3'b100
    } vrac_fn_e;
endpackage : vrac_pkg

// >>> verilog/vrac_logic_unit.sv
// five-function byte logic unit for read-modify-write
`timescale 1ns/1ns
`default_nettype none
module vrac_logic_unit (
    // operands
    input wire logic [7:0] new_byte_i,
    input wire logic [7:0] old_byte_i,
    // function select
    input wire logic [2:0] func_i,
    // result
    output logic [7:0] result_o
);
    always_comb begin
        case (func_i)
            vrac_pkg::VRAC_FN_XOR: result_o = new_byte_i ^ old_byte_i;
            vrac_pkg::VRAC_FN_OR: result_o = new_byte_i | old_byte_i;
            vrac_pkg::VRAC_FN_NOT_NEW: result_o = ~new_byte_i;
            vrac_pkg::VRAC_FN_NOT_OLD: result_o = ~old_byte_i;
            // unused codes fall back to pass-through
            default: result_o = new_byte_i;
        endcase
    end
endmodule : vrac_logic_unit
`default_nettype wire

// >>> verilog/vrac_top.sv
// screen-memory access controller: address mux, strobes, rmw and video serializer
`timescale 1ns/1ns
`default_nettype none
module vrac_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // processor side
    input wire logic [12:0] cpu_addr_i,
    input wire logic [7:0] cpu_wdata_i,
    input wire logic [2:0] alu_func_i,
    input wire logic mem_request_n_i,
    input wire logic refresh_cycle_n_i,
    input wire logic cpu_read_n_i,
    input wire logic cpu_write_n_i,
    input wire logic screen_select_i,
    output logic [7:0] cpu_rdata_o,
    output logic cpu_rdata_oe_n_o,
    // vertical count from the sync counters
    input wire logic [7:0] vcount_i,
    // screen ram
    output logic [5:0] ram_addr_o,
    output logic ram_row_strobe_n_o,
    output logic ram_col_strobe_n_o,
    output logic [1:0] ram_chip_select_n_o,
    output logic ram_write_enable_n_o,
    input wire logic [7:0] ram_rdata_i,
    output logic [7:0] ram_wdata_o,
    output logic ram_wdata_oe_n_o,
    // video
    output logic video_serial_o,
    output logic video_cycle_n_o
);
    // input synchronisers: three stages, change taken once stages two and three agree
    logic [vrac_pkg::SY_W-1:0] sync1_reg, sync1_next;
    logic [vrac_pkg::SY_W-1:0] sync2_reg, sync2_next;
    logic [vrac_pkg::SY_W-1:0] sync3_reg, sync3_next;
    logic [vrac_pkg::SY_W-1:0] filt_reg, filt_next;

    // pixel timing
    logic [1:0] div_reg, div_next;
    logic [8:0] hcount_reg, hcount_next;
    logic pixel_tick;

    // strobe generation
    logic write_enable_window_reg, write_enable_window_next;
    logic video_row_request_reg, video_row_request_next;
    logic cpu_row_request_reg, cpu_row_request_next;
    logic ras_dly_reg, ras_dly_next;
    logic ras_n_reg, ras_n_next;
    logic cas_n_reg, cas_n_next;
    logic [1:0] cs_n_reg, cs_n_next;
    logic we_n_reg, we_n_next;
    logic [5:0] addr_reg, addr_next;
    logic vcn_reg, vcn_next;

    // data path
    logic [7:0] rd_latch_reg, rd_latch_next;
    logic [7:0] wdata_reg, wdata_next;
    logic wdata_oe_n_reg, wdata_oe_n_next;
    logic [7:0] cpu_rdata_reg, cpu_rdata_next;
    logic cpu_rdata_oe_n_reg, cpu_rdata_oe_n_next;
    logic [7:0] vid_byte_reg, vid_byte_next;
    logic [7:0] shift_reg, shift_next;
    logic serial_reg, serial_next;

    // combinational helpers
    logic video_cycle_n;
    logic shift_load_n;
    logic cpu_set;
    logic cpu_write;
    logic cpu_read;
    logic [7:0] alu_result;
    logic [7:0] old_byte;
    vrac_pkg::vrac_sel_e sel;

    // the logic unit takes the latch input while it is transparent, so the modified byte
    // is ready in the same clock in which the write strobe falls
    assign old_byte = we_n_reg ? ram_rdata_i : rd_latch_reg;

    vrac_logic_unit u_logic_unit (
        .new_byte_i(cpu_wdata_i),
        .old_byte_i(old_byte),
        .func_i(alu_func_i),
        .result_o(alu_result)
    );

    always_comb begin
        // synchronisers
        // a pulse shorter than two clocks never reaches the filtered copy
        sync1_next = {screen_select_i, cpu_write_n_i, cpu_read_n_i, refresh_cycle_n_i, mem_request_n_i};
        sync2_next = sync1_reg;
        sync3_next = sync2_reg;
        filt_next = filt_reg;
        for (int i = 0; i < vrac_pkg::SY_W; i++) begin
            if (sync2_reg[i] == sync3_reg[i]) begin
                filt_next[i] = sync3_reg[i];
            end
        end

        // pixel tick every 200 ns from the single 20 MHz clock
        pixel_tick = (div_reg == vrac_pkg::PIXEL_DIV_LAST);
        div_next = pixel_tick ? 2'h0 : div_reg + 2'h1;
        // count wraps after retrace, giving 320 pixels per line
        hcount_next = hcount_reg;
        if (pixel_tick) begin
            hcount_next = (hcount_reg == vrac_pkg::H_LAST) ? 9'h000 : hcount_reg + 9'h001;
        end

        // video cycle: low while hcount bit 2 low, held off during retrace
        video_cycle_n = hcount_reg[vrac_pkg::HB2] | hcount_reg[vrac_pkg::HB8];
        vcn_next = video_cycle_n;

        cpu_write = ~filt_reg[vrac_pkg::SY_WR];
        cpu_read = ~filt_reg[vrac_pkg::SY_RD];

        // processor request gating: only in the idle half of a byte time
        // in the active line this window is a single pixel: the processor must end its cycle
        // with refresh before the next video row, as nothing here arbitrates between them
        cpu_set = hcount_reg[vrac_pkg::HB1] & video_cycle_n & filt_reg[vrac_pkg::SY_SEL]
                  & ~hcount_reg[vrac_pkg::HB0] & ~filt_reg[vrac_pkg::SY_MEM_REQUEST_N];

        write_enable_window_next = write_enable_window_reg;
        video_row_request_next = video_row_request_reg;
        cpu_row_request_next = cpu_row_request_reg;
        ras_dly_next = ras_dly_reg;
        if (pixel_tick) begin
            write_enable_window_next = ~hcount_reg[vrac_pkg::HB1] & hcount_reg[vrac_pkg::HB0] ? 1'b0
                                       : (~hcount_reg[vrac_pkg::HB0] & hcount_reg[vrac_pkg::HB1]);
            video_row_request_next = ~(video_cycle_n | write_enable_window_reg);
            if (cpu_set) begin
                cpu_row_request_next = 1'b1;
            end
            // register stage of the row-to-column delay
            // it advances on the pixel tick, so a processor column phase trails its row by a pixel
            ras_dly_next = video_row_request_reg | cpu_row_request_reg;
        end
        // refresh after an opcode fetch ends the processor cycle; it wins over a set
        if (~filt_reg[vrac_pkg::SY_REFRESH_CYCLE_N]) begin
            cpu_row_request_next = 1'b0;
        end

        // row strobe is the nor of both requests
        ras_n_next = ~(video_row_request_reg | cpu_row_request_reg);
        // extra clock-phase stage models the analogue delay, so column always trails row
        cas_n_next = ~(ras_dly_reg & ~ras_n_reg);

        // address select: upper bit from video cycle, lower from column timing
        // the address is registered like the strobes, so both change on the same edge
        sel = vrac_pkg::vrac_sel_e'({vcn_reg, ras_dly_reg});
        case (sel)
            vrac_pkg::VRAC_SEL_VID_ROW: addr_next = {vcount_i[1:0], hcount_reg[7:4]};
            vrac_pkg::VRAC_SEL_VID_COL: addr_next = vcount_i[7:2];
            vrac_pkg::VRAC_SEL_CPU_ROW: addr_next = cpu_addr_i[6:1];
            vrac_pkg::VRAC_SEL_CPU_COL: addr_next = cpu_addr_i[12:7];
            default: addr_next = vrac_pkg::ADDR_RST;
        endcase

        // chip select drops with the row strobe, ahead of the column strobe
        // hcount bit 3 alternates the banks from one video byte to the next
        cs_n_next = vrac_pkg::CS_IDLE;
        if (video_row_request_reg) begin
            cs_n_next = hcount_reg[vrac_pkg::HB3] ? 2'h1 : 2'h2;
        end else if (cpu_row_request_reg) begin
            cs_n_next = cpu_addr_i[0] ? 2'h1 : 2'h2;
        end

        // write strobe falls one clock after the column strobe, inside the same cycle
        we_n_next = ~(cpu_row_request_reg & ~cas_n_reg & cpu_write);

        // read latch transparent while the write strobe is high; the held copy feeds read-back,
        // video capture and, while the write strobe is low, the logic unit
        rd_latch_next = old_byte;

        // modified byte is driven only while the write strobe is low
        wdata_next = alu_result;
        wdata_oe_n_next = we_n_next;

        // processor read-back stays off during a write
        cpu_rdata_next = cpu_rdata_reg;
        cpu_rdata_oe_n_next = 1'b1;
        if (cpu_row_request_reg & cpu_read & ~cpu_write & we_n_reg) begin
            cpu_rdata_oe_n_next = 1'b0;
            if (~cas_n_reg) begin
                cpu_rdata_next = rd_latch_reg;
            end
        end

        // capture the video byte only on a video read with no write
        vid_byte_next = vid_byte_reg;
        if (video_row_request_reg & ~cas_n_reg & we_n_reg) begin
            vid_byte_next = rd_latch_reg;
        end

        // serializer: load on the last pixel of a byte, else shift msb first
        // no load during retrace, so the line tail shifts out zeros
        shift_load_n = ~((hcount_reg[2:0] == vrac_pkg::BYTE_LOAD_PIXEL) & ~hcount_reg[vrac_pkg::HB8]);
        shift_next = shift_reg;
        serial_next = serial_reg;
        if (pixel_tick) begin
            if (~shift_load_n) begin
                shift_next = vid_byte_reg;
            end else begin
                shift_next = {shift_reg[6:0], 1'b0};
            end
            serial_next = shift_reg[7];
        end
    end

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            sync1_reg <= vrac_pkg::SYNC_RST;
            sync2_reg <= vrac_pkg::SYNC_RST;
            sync3_reg <= vrac_pkg::SYNC_RST;
            filt_reg <= vrac_pkg::SYNC_RST;
            div_reg <= 2'h0;
            hcount_reg <= 9'h000;
            write_enable_window_reg <= 1'b0;
            video_row_request_reg <= 1'b0;
            cpu_row_request_reg <= 1'b0;
            ras_dly_reg <= 1'b0;
            ras_n_reg <= vrac_pkg::STROBE_IDLE;
            cas_n_reg <= vrac_pkg::STROBE_IDLE;
            cs_n_reg <= vrac_pkg::CS_IDLE;
            we_n_reg <= vrac_pkg::STROBE_IDLE;
            addr_reg <= vrac_pkg::ADDR_RST;
            vcn_reg <= 1'b0;
            rd_latch_reg <= vrac_pkg::BYTE_RST;
            wdata_reg <= vrac_pkg::BYTE_RST;
            wdata_oe_n_reg <= 1'b1;
            cpu_rdata_reg <= vrac_pkg::BYTE_RST;
            cpu_rdata_oe_n_reg <= 1'b1;
            vid_byte_reg <= vrac_pkg::BYTE_RST;
            shift_reg <= vrac_pkg::BYTE_RST;
            serial_reg <= 1'b0;
        end else begin
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            sync3_reg <= sync3_next;
            filt_reg <= filt_next;
            div_reg <= div_next;
            hcount_reg <= hcount_next;
            write_enable_window_reg <= write_enable_window_next;
            video_row_request_reg <= video_row_request_next;
            cpu_row_request_reg <= cpu_row_request_next;
            ras_dly_reg <= ras_dly_next;
            ras_n_reg <= ras_n_next;
            cas_n_reg <= cas_n_next;
            cs_n_reg <= cs_n_next;
            we_n_reg <= we_n_next;
            addr_reg <= addr_next;
            vcn_reg <= vcn_next;
            rd_latch_reg <= rd_latch_next;
            wdata_reg <= wdata_next;
            wdata_oe_n_reg <= wdata_oe_n_next;
            cpu_rdata_reg <= cpu_rdata_next;
            cpu_rdata_oe_n_reg <= cpu_rdata_oe_n_next;
            vid_byte_reg <= vid_byte_next;
            shift_reg <= shift_next;
            serial_reg <= serial_next;
        end
    end

    // all outputs straight from flip-flops
    assign ram_addr_o = addr_reg;
    assign ram_row_strobe_n_o = ras_n_reg;
    assign ram_col_strobe_n_o = cas_n_reg;
    assign ram_chip_select_n_o = cs_n_reg;
    assign ram_write_enable_n_o = we_n_reg;
    assign ram_wdata_o = wdata_reg;
    assign ram_wdata_oe_n_o = wdata_oe_n_reg;
    assign cpu_rdata_o = cpu_rdata_reg;
    assign cpu_rdata_oe_n_o = cpu_rdata_oe_n_reg;
    assign video_serial_o = serial_reg;
    assign video_cycle_n_o = vcn_reg;
endmodule : vrac_top
`default_nettype wire

// >>> testbench/vrac_monitor.sv
// bound assertions on the screen-memory access controller ports
`timescale 1ns/1ns
`default_nettype none
module vrac_monitor (
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // processor side and vertical count
    input wire logic [12:0] cpu_addr_i,
    input wire logic cpu_rdata_oe_n_o,
    input wire logic [7:0] vcount_i,
    // screen ram and video
    input wire logic [5:0] ram_addr_o,
    input wire logic ram_row_strobe_n_o,
    input wire logic ram_col_strobe_n_o,
    input wire logic [1:0] ram_chip_select_n_o,
    input wire logic ram_write_enable_n_o,
    input wire logic ram_wdata_oe_n_o,
    input wire logic video_cycle_n_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (srst_i);
    sequence row_fall_s;
        $fell(ram_row_strobe_n_o);
    endsequence
    sequence col_fall_s;
        $fell(ram_col_strobe_n_o);
    endsequence
    sequence we_fall_s;
        $fell(ram_write_enable_n_o);
    endsequence
    a_col_after_row: assert property (row_fall_s |-> ##[1:10] col_fall_s)
        else $error("column strobe did not follow the row strobe");
    a_select_before_col: assert property (col_fall_s |-> ram_chip_select_n_o != 2'h3)
        else $error("column strobe fell with no chip select");
    a_write_after_col: assert property (we_fall_s |-> $past(ram_col_strobe_n_o) == 1'b0 && !ram_row_strobe_n_o)
        else $error("write enable fell before the column strobe");
    a_write_drives_bus: assert property (we_fall_s |-> !ram_wdata_oe_n_o)
        else $error("write enable low with ram data not driven");
    a_readback_quiet: assert property (!ram_write_enable_n_o |-> cpu_rdata_oe_n_o)
        else $error("read-back driver enabled during a write");
    a_cpu_row_addr: assert property (video_cycle_n_o ##0 row_fall_s |-> ram_addr_o == cpu_addr_i[6:1])
        else $error("processor row address wrong");
    a_cpu_col_addr: assert property (video_cycle_n_o ##0 col_fall_s |-> ram_addr_o == cpu_addr_i[12:7])
        else $error("processor column address wrong");
    a_video_col_addr: assert property (!video_cycle_n_o ##0 col_fall_s |-> ram_addr_o == vcount_i[7:2])
        else $error("video column address wrong");
    a_video_row_addr: assert property (!video_cycle_n_o ##0 row_fall_s |-> ram_addr_o[5:4] == vcount_i[1:0])
        else $error("video row address wrong");
    a_video_half_len: assert property ($fell(video_cycle_n_o) |-> (!video_cycle_n_o) [*8])
        else $error("video cycle half shorter than expected");
endmodule : vrac_monitor
bind vrac_top vrac_monitor mon (.clk_i, .srst_i, .cpu_addr_i, .cpu_rdata_oe_n_o, .vcount_i, .ram_addr_o,
    .ram_row_strobe_n_o, .ram_col_strobe_n_o, .ram_chip_select_n_o, .ram_write_enable_n_o,
    .ram_wdata_oe_n_o, .video_cycle_n_o);
`default_nettype wire

// >>> testbench/vrac_ram_model.sv
// behavioural screen ram: two banks of 4096 bytes behind row and column strobes
`timescale 1ns/1ns
`default_nettype none
module vrac_ram_model (
    // clock
    input wire logic clk_i,
    // strobes, address and data from the controller
    input wire logic [5:0] addr_i,
    input wire logic row_n_i,
    input wire logic col_n_i,
    input wire logic [1:0] cs_n_i,
    input wire logic we_n_i,
    input wire logic [7:0] wdata_i,
    // read data; an unselected ram shows a changing pattern, not the last byte
    output logic [7:0] rdata_o
);
    logic [7:0] mem [0:8191];
    logic [5:0] row_reg, col_reg;
    logic row_q, col_q, we_q;
    logic [7:0] junk_reg = 8'h55;
    logic bank;
    assign bank = ~cs_n_i[1];
    assign rdata_o = (!col_n_i && cs_n_i != 2'h3) ? mem[{bank, addr_i, row_reg}] : junk_reg;
    always @(posedge clk_i) begin
        junk_reg <= ~junk_reg;
        row_q <= row_n_i;
        col_q <= col_n_i;
        we_q <= we_n_i;
        if (row_q && !row_n_i) row_reg <= addr_i;
        if (col_q && !col_n_i) col_reg <= addr_i;
        if (we_q && !we_n_i) mem[{bank, col_reg, row_reg}] <= wdata_i;
    end
endmodule : vrac_ram_model
`default_nettype wire

// >>> testbench/vrac_top_test.sv
// self-checking bench for the screen-memory access controller
`timescale 1ns/1ns
`default_nettype none
module vrac_top_test;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic [12:0] cpu_addr_i = 13'h0000;
    logic [7:0] cpu_wdata_i = 8'h00;
    logic [2:0] alu_func_i = 3'h0;
    logic mem_request_n_i = 1'b1;
    logic refresh_cycle_n_i = 1'b1;
    logic cpu_read_n_i = 1'b1;
    logic cpu_write_n_i = 1'b1;
    logic screen_select_i = 1'b0;
    logic [7:0] vcount_i = 8'h5a;
    logic [7:0] cpu_rdata_o, ram_rdata_i, ram_wdata_o;
    logic [5:0] ram_addr_o;
    logic [1:0] ram_chip_select_n_o;
    logic cpu_rdata_oe_n_o, ram_row_strobe_n_o, ram_col_strobe_n_o, ram_write_enable_n_o;
    logic ram_wdata_oe_n_o, video_serial_o, video_cycle_n_o;
    int n_errors = 0;
    int n_checks = 0;
    vrac_top dut (.clk_i, .srst_i, .cpu_addr_i, .cpu_wdata_i, .alu_func_i, .mem_request_n_i, .refresh_cycle_n_i,
        .cpu_read_n_i, .cpu_write_n_i, .screen_select_i, .cpu_rdata_o, .cpu_rdata_oe_n_o, .vcount_i, .ram_addr_o,
        .ram_row_strobe_n_o, .ram_col_strobe_n_o, .ram_chip_select_n_o, .ram_write_enable_n_o, .ram_rdata_i,
        .ram_wdata_o, .ram_wdata_oe_n_o, .video_serial_o, .video_cycle_n_o);
    vrac_ram_model ram (.clk_i, .addr_i(ram_addr_o), .row_n_i(ram_row_strobe_n_o), .col_n_i(ram_col_strobe_n_o),
        .cs_n_i(ram_chip_select_n_o), .we_n_i(ram_write_enable_n_o), .wdata_i(ram_wdata_o), .rdata_o(ram_rdata_i));
    initial begin
        forever #25 clk_i = ~clk_i;
    end
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic conclude();
        if (n_errors == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : conclude
    function automatic logic [12:0] idx(input logic [12:0] a);
        return {a[0], a[12:7], a[6:1]};
    endfunction : idx
    function automatic logic [7:0] alu_ref(input logic [2:0] f, input logic [7:0] a, input logic [7:0] b);
        case (f)
            3'h1: return a ^ b;
            3'h2: return a | b;
            3'h3: return ~a;
            3'h4: return ~b;
            default: return a;
        endcase
    endfunction : alu_ref
    // the cpu strobe is recognised by its own enables, so a video strobe is never mistaken for it
    task automatic wait_cpu(input logic wr);
        int n;
        n = 0;
        while (wr ? ram_write_enable_n_o !== 1'b0 : (cpu_rdata_oe_n_o !== 1'b0 || ram_col_strobe_n_o !== 1'b0)) begin
            @(negedge clk_i);
            n++;
            if (n > 3000) begin
                check("cpu strobe timeout", 16'h0001, 16'h0000);
                conclude();
            end
        end
    endtask : wait_cpu
    // processor cycles sit in the line retrace, the only window wide enough for the
    // synchronisers and the refresh that must end the cycle before the next video row
    task automatic wait_retrace();
        int run, n;
        run = -1000;
        n = 0;
        while (run < 20) begin
            @(negedge clk_i);
            run = (video_cycle_n_o === 1'b1) ? run + 1 : 0;
            n++;
            if (n > 3000) begin
                check("retrace timeout", 16'h0001, 16'h0000);
                conclude();
            end
        end
    endtask : wait_retrace
    task automatic cpu_cycle(input logic [12:0] a, input logic [7:0] d, input logic [2:0] f, input logic wr,
        output logic [7:0] rd);
        wait_retrace();
        cpu_addr_i = a;
        cpu_wdata_i = d;
        alu_func_i = f;
        cpu_read_n_i = wr;
        cpu_write_n_i = !wr;
        screen_select_i = 1'b1;
        mem_request_n_i = 1'b0;
        wait_cpu(wr);
        repeat (3) @(negedge clk_i);
        rd = cpu_rdata_o;
        if (!wr) check("read driver", 16'h0000, {15'h0, cpu_rdata_oe_n_o});
        refresh_cycle_n_i = 1'b0;
        mem_request_n_i = 1'b1;
        cpu_read_n_i = 1'b1;
        cpu_write_n_i = 1'b1;
        screen_select_i = 1'b0;
        repeat (8) @(negedge clk_i);
        check("write enable after refresh", 16'h0001, {15'h0, ram_write_enable_n_o});
        check("read driver after refresh", 16'h0001, {15'h0, cpu_rdata_oe_n_o});
        refresh_cycle_n_i = 1'b1;
        repeat (4) @(negedge clk_i);
    endtask : cpu_cycle
    task automatic t_reset();
        logic [6:0] idle;
        @(negedge clk_i);
        srst_i = 1'b1;
        repeat (4) @(negedge clk_i);
        idle = {ram_row_strobe_n_o, ram_col_strobe_n_o, ram_write_enable_n_o, ram_chip_select_n_o,
            cpu_rdata_oe_n_o, ram_wdata_oe_n_o};
        check("idle strobes and enables", 16'h007f, {9'h0, idle});
        srst_i = 1'b0;
        repeat (8) @(negedge clk_i);
    endtask : t_reset
    // any 1280 consecutive clocks span exactly one line, so the counts do not depend on the phase
    task automatic t_video_line();
        int low, falls, bank1;
        logic prev;
        low = 0;
        falls = 0;
        bank1 = 0;
        prev = ram_col_strobe_n_o;
        repeat (1280) begin
            @(negedge clk_i);
            if (video_cycle_n_o === 1'b0) low++;
            if (prev === 1'b1 && ram_col_strobe_n_o === 1'b0) begin
                falls++;
                if (ram_chip_select_n_o === 2'h1) bank1++;
            end
            prev = ram_col_strobe_n_o;
        end
        check("video low clocks per line", 16'h0200, 16'(low));
        check("video reads per line", 16'h0020, 16'(falls));
        check("bank one reads per line", 16'h0010, 16'(bank1));
    endtask : t_video_line
    task automatic t_write_funcs();
        logic [12:0] a;
        logic [7:0] rd;
        for (int f = 0; f < 6; f++) begin
            a = 13'(13'h0b4d + f * 413);
            ram.mem[idx(a)] = 8'h3c;
            cpu_cycle(a, 8'ha5, 3'(f), 1'b1, rd);
            check("stored byte", {8'h0, alu_ref(3'(f), 8'ha5, 8'h3c)}, {8'h0, ram.mem[idx(a)]});
        end
    endtask : t_write_funcs
    task automatic t_read_back();
        logic [7:0] rd;
        ram.mem[idx(13'h1e2a)] = 8'hc3;
        cpu_cycle(13'h1e2a, 8'h00, 3'h0, 1'b0, rd);
        check("read byte", 16'h00c3, {8'h0, rd});
        cpu_cycle(13'h0795, 8'h69, 3'h0, 1'b1, rd);
        cpu_cycle(13'h0795, 8'h00, 3'h1, 1'b0, rd);
        check("read after write", 16'h0069, {8'h0, rd});
    endtask : t_read_back
    // bank one bytes are all ones and bank zero bytes one set bit: 16*8 + 16*1 pixels of 4 clocks
    task automatic t_video_serial();
        int high;
        high = 0;
        for (int i = 0; i < 32; i++) begin
            ram.mem[{i[0], 6'h16, 2'h2, i[4:1]}] = i[0] ? 8'hff : 8'h80;
        end
        repeat (1280) @(negedge clk_i);
        repeat (1280) begin
            @(negedge clk_i);
            if (video_serial_o === 1'b1) high++;
        end
        check("serial high clocks per line", 16'h0240, 16'(high));
    endtask : t_video_serial
    task automatic t_refused();
        int hits;
        hits = 0;
        @(negedge clk_i);
        cpu_write_n_i = 1'b0;
        mem_request_n_i = 1'b0;
        repeat (1400) begin
            @(negedge clk_i);
            if (ram_write_enable_n_o !== 1'b1) hits++;
        end
        mem_request_n_i = 1'b1;
        cpu_write_n_i = 1'b1;
        check("writes without select", 16'h0000, 16'(hits));
        repeat (8) @(negedge clk_i);
    endtask : t_refused
    initial begin
        t_reset();
        t_video_line();
        t_write_funcs();
        t_read_back();
        t_video_serial();
        t_refused();
        t_reset();
        t_video_line();
        conclude();
    end
endmodule : vrac_top_test
`default_nettype wire
